// ---- src/spid_pkg.sv ----
package spid_pkg;

	// ----------------------------------------------------------------
	// instruction codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_ENABLE_INSTR  = 8'h06;
	localparam logic [7:0] OP_RDSR  = 8'h05;
	localparam logic [7:0] OP_ERASE = 8'h44;
	localparam logic [7:0] OP_PROG  = 8'h42;
	localparam logic [7:0] OP_READ  = 8'h48;
	localparam logic [7:0] OP_SLEEP = 8'hB9;
	localparam logic [7:0] OP_SIG   = 8'hAB;
	localparam logic [7:0] OP_ID    = 8'h90;
	localparam logic [7:0] OP_NONE  = 8'h00;

	// ----------------------------------------------------------------
	// identity bytes: values are arbitrary
	// ----------------------------------------------------------------
	localparam logic [7:0] SIG_CODE = 8'h3C;
	localparam logic [7:0] MFR_CODE = 8'hA5;
	localparam logic [7:0] DEV_CODE = 8'h3C;

	// ----------------------------------------------------------------
	// security areas and status layout
	// ----------------------------------------------------------------
	localparam int         AREA_BYTES = 1024;
	localparam int         AREAS      = 3;
	localparam logic [9:0] OFF_LAST   = 10'h3FF;
	localparam logic [7:0] ERASED     = 8'hFF;
	localparam int         ST_WIP     = 0;
	localparam int         ST_WEL     = 1;
	localparam int         ADDR_BYTES = 3;
	localparam int         READ_HDR   = 4;
	localparam int         PROG_HDR   = 4;

	// ----------------------------------------------------------------
	// timing: printed times in microseconds, counts at 50 ns clock
	// ----------------------------------------------------------------
	localparam int CLK_NS        = 50;
	localparam int ERASE_TIME_US = 200;
	localparam int PROG_TIME_US  = 60;
	localparam int SLEEP_TIME_US = 3;
	localparam int WAKE_TIME_US  = 8;
	localparam int ERASE_CYC     = (ERASE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int PROG_CYC      = (PROG_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int SLEEP_CYC     = (SLEEP_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_CYC      = (WAKE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------------------------------
	// self-timed activity
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ERASE = 3'b001,
		ST_PROG  = 3'b011,
		ST_SLPW  = 3'b010,
		ST_WAKEW = 3'b110
	} spid_state_t;

endpackage

// ---- src/spid_flash.sv ----
`timescale 1ns/10ps

module spid_flash #(
	parameter int ERASE_CYC = spid_pkg::ERASE_CYC,
	parameter int PROG_CYC  = spid_pkg::PROG_CYC,
	parameter int SLEEP_CYC = spid_pkg::SLEEP_CYC,
	parameter int WAKE_CYC  = spid_pkg::WAKE_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       cs_n_i,
	input  wire logic       sclk_i,
	input  wire logic       si_i,
	input  wire logic [2:0] security_lock_bits_i,
	output logic            so_o,
	output logic            so_oe_o,
	output logic            write_in_progress_o,
	output logic            write_enable_latch_o,
	output logic            deep_sleep_o
);

	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	// the cycle walks every byte of an area, so it cannot be shorter
	if (ERASE_CYC < spid_pkg::AREA_BYTES || PROG_CYC < spid_pkg::AREA_BYTES ||
			ERASE_CYC > 65536 || PROG_CYC > 65536 || SLEEP_CYC < 1 ||
			WAKE_CYC < 1 || SLEEP_CYC > 65536 || WAKE_CYC > 65536) begin : g_bad
		$error("spid_flash: cycle counts out of range");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0]            cs_p;
		logic [2:0]            ck_p;
		logic [1:0]            si_p;
		logic [2:0]            bit_cnt;
		logic [10:0]           byte_cnt;
		logic [7:0]            shreg;
		logic [7:0]            opcode;
		logic [23:0]           addr;
		logic [9:0]            off;
		logic [7:0]            tx;
		logic                  so;
		logic                  so_en;
		logic                  id_sel;
		logic                  write_enable_latch;
		logic                  asleep;
		logic                  ovr;
		spid_pkg::spid_state_t state;
		logic [15:0]           tmr;
		logic [1:0]            area;
		logic [10:0]           idx;
		logic [1:0][17:0]      fq;
		logic [1:0]            f_cnt;
		logic                  f_wp;
		logic                  f_rp;
	} spid_regs_t;

	spid_regs_t r_reg;
	spid_regs_t r_next;

	logic [7:0]  sec_mem [spid_pkg::AREAS * spid_pkg::AREA_BYTES];
	logic [7:0]  stage_mem [spid_pkg::AREA_BYTES];
	logic [spid_pkg::AREA_BYTES-1:0] stage_vld_reg;

	logic        cs_low;
	logic        cs_rise;
	logic        ck_rise;
	logic        ck_fall;
	logic [7:0]  in_byte;
	logic        byte_done;
	logic        write_in_progress;
	logic [7:0]  status;
	logic [7:0]  rd_byte;
	logic        pop;
	logic        clr_stage;
	logic        exact;
	logic        may_write;

	// area index from bits 13-12, which hold 1..3 for a valid address
	function automatic logic [1:0] area_of(input logic [23:0] a);
		area_of = a[13:12] - 2'd1;
	endfunction

	// address names one of the three areas
	function automatic logic addr_ok(input logic [23:0] a);
		addr_ok = (a[23:16] == 8'h00) && (a[11:10] == 2'b00) &&
			(a[15:14] == 2'b00) && (a[13:12] != 2'b00);
	endfunction

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	assign cs_low    = !r_reg.cs_p[1];
	assign cs_rise   = r_reg.cs_p[1] && !r_reg.cs_p[2];
	assign ck_rise   = r_reg.ck_p[1] && !r_reg.ck_p[2];
	assign ck_fall   = !r_reg.ck_p[1] && r_reg.ck_p[2];
	assign in_byte   = {r_reg.shreg[6:0], r_reg.si_p[1]};
	assign byte_done = cs_low && ck_rise && (r_reg.bit_cnt == 3'd7);
	assign write_in_progress       = (r_reg.state == spid_pkg::ST_ERASE) ||
		(r_reg.state == spid_pkg::ST_PROG);
	assign status    = {6'h00, r_reg.write_enable_latch, write_in_progress};
	assign rd_byte   = sec_mem[{area_of(r_reg.addr), r_reg.off}];
	// the staging drain stalls while a program walks the staged bytes
	assign pop       = (r_reg.f_cnt != 2'd0) && (r_reg.state != spid_pkg::ST_PROG);
	assign clr_stage = byte_done && (r_reg.byte_cnt == 11'd0) &&
		(in_byte == spid_pkg::OP_PROG) && (r_reg.state == spid_pkg::ST_IDLE) &&
		!r_reg.asleep;
	assign exact     = (r_reg.bit_cnt == 3'd0);
	assign may_write = r_reg.write_enable_latch && addr_ok(r_reg.addr) &&
		!security_lock_bits_i[area_of(r_reg.addr)];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		// pins pass two flops before use
		r_next.cs_p = {r_reg.cs_p[1:0], cs_n_i};
		r_next.ck_p = {r_reg.ck_p[1:0], sclk_i};
		r_next.si_p = {r_reg.si_p[0], si_i};

		// self-timed cycles
		unique case (r_reg.state)
			spid_pkg::ST_IDLE: begin
			end
			spid_pkg::ST_ERASE, spid_pkg::ST_PROG: begin
				if (r_reg.idx != 11'(spid_pkg::AREA_BYTES))
					r_next.idx = r_reg.idx + 11'd1;
				if (r_reg.tmr == 16'h0000) begin
					r_next.state = spid_pkg::ST_IDLE;
					r_next.write_enable_latch   = 1'b0;
				end else begin
					r_next.tmr = r_reg.tmr - 16'h0001;
				end
			end
			spid_pkg::ST_SLPW: begin
				if (r_reg.tmr == 16'h0000) begin
					r_next.state  = spid_pkg::ST_IDLE;
					r_next.asleep = 1'b1;
				end else begin
					r_next.tmr = r_reg.tmr - 16'h0001;
				end
			end
			spid_pkg::ST_WAKEW: begin
				if (r_reg.tmr == 16'h0000) begin
					r_next.state  = spid_pkg::ST_IDLE;
					r_next.asleep = 1'b0;
				end else begin
					r_next.tmr = r_reg.tmr - 16'h0001;
				end
			end
		endcase

		// staging buffer drain
		if (pop) begin
			r_next.f_rp = ~r_reg.f_rp;
		end

		if (!cs_low) begin
			r_next.bit_cnt  = 3'd0;
			r_next.byte_cnt = 11'd0;
			r_next.so_en    = 1'b0;
		end else if (ck_rise) begin
			r_next.shreg   = in_byte;
			r_next.bit_cnt = r_reg.bit_cnt + 3'd1;
		end

		// whole byte in: decode or carry the transfer on
		if (byte_done) begin
			if (r_reg.byte_cnt != 11'h7FF)
				r_next.byte_cnt = r_reg.byte_cnt + 11'd1;
			if (r_reg.byte_cnt == 11'd0) begin
				r_next.ovr    = 1'b0;
				r_next.opcode = spid_pkg::OP_NONE;
				if (write_in_progress) begin
					if (in_byte == spid_pkg::OP_RDSR)
						r_next.opcode = in_byte;
				end else if (r_reg.asleep || r_reg.state != spid_pkg::ST_IDLE) begin
					if (in_byte == spid_pkg::OP_SIG && r_reg.state != spid_pkg::ST_WAKEW)
						r_next.opcode = in_byte;
				end else begin
					r_next.opcode = in_byte;
				end
				if (r_next.opcode == spid_pkg::OP_SIG) begin
					r_next.tx    = spid_pkg::SIG_CODE;
					r_next.so_en = 1'b1;
				end
				if (r_next.opcode == spid_pkg::OP_RDSR) begin
					r_next.tx    = status;
					r_next.so_en = 1'b1;
				end
			end else begin
				if (r_reg.byte_cnt <= 11'(spid_pkg::ADDR_BYTES))
					r_next.addr = {r_reg.addr[15:0], in_byte};
				if (r_reg.byte_cnt == 11'(spid_pkg::ADDR_BYTES))
					r_next.off = {r_reg.addr[1:0], in_byte};
				unique case (r_reg.opcode)
					spid_pkg::OP_SIG: begin
						r_next.tx = spid_pkg::SIG_CODE;
					end
					spid_pkg::OP_RDSR: begin
						r_next.tx = status;
					end
					spid_pkg::OP_ID: begin
						if (r_reg.byte_cnt >= 11'(spid_pkg::ADDR_BYTES)) begin
							r_next.id_sel = (r_reg.byte_cnt == 11'(spid_pkg::ADDR_BYTES)) ?
								in_byte[0] : ~r_reg.id_sel;
							r_next.tx     = r_next.id_sel ? spid_pkg::DEV_CODE :
								spid_pkg::MFR_CODE;
							r_next.so_en  = 1'b1;
						end
					end
					spid_pkg::OP_READ: begin
						if (r_reg.byte_cnt >= 11'(spid_pkg::READ_HDR)) begin
							r_next.tx    = addr_ok(r_reg.addr) ? rd_byte : spid_pkg::ERASED;
							r_next.off   = r_reg.off + 10'd1;
							r_next.so_en = 1'b1;
						end
					end
					spid_pkg::OP_PROG: begin
						if (r_reg.byte_cnt >= 11'(spid_pkg::PROG_HDR)) begin
							r_next.off = r_reg.off + 10'd1;
							if (r_reg.f_cnt == 2'd2) begin
								r_next.ovr = 1'b1;
							end else begin
								r_next.fq[r_reg.f_wp] = {r_reg.off, in_byte};
								r_next.f_wp = ~r_reg.f_wp;
							end
						end
					end
					default: begin
					end
				endcase
			end
		end

		// falling clock edges shift the prepared byte out, msb first
		if (cs_low && ck_fall && r_reg.so_en) begin
			r_next.so = r_reg.tx[7];
			r_next.tx = {r_reg.tx[6:0], 1'b0};
		end

		// buffer occupancy after push and pop
		r_next.f_cnt = r_reg.f_cnt + {1'b0, r_next.f_wp != r_reg.f_wp} -
			{1'b0, pop};

		// select rising commits the instruction
		if (cs_rise) begin
			r_next.opcode = spid_pkg::OP_NONE;
			r_next.so     = 1'b0;
			unique case (r_reg.opcode)
				spid_pkg::OP_WRITE_ENABLE_INSTR: begin
					if (exact && r_reg.byte_cnt == 11'd1)
						r_next.write_enable_latch = 1'b1;
				end
				spid_pkg::OP_SLEEP: begin
					if (exact && r_reg.byte_cnt == 11'd1) begin
						r_next.state = spid_pkg::ST_SLPW;
						r_next.tmr   = 16'(SLEEP_CYC - 1);
					end
				end
				spid_pkg::OP_SIG: begin
					// exact release or at least one signature read out
					if (r_reg.asleep && ((exact && r_reg.byte_cnt == 11'd1) ||
							r_reg.byte_cnt >= 11'd2)) begin
						r_next.state = spid_pkg::ST_WAKEW;
						r_next.tmr   = 16'(WAKE_CYC - 1);
					end
				end
				spid_pkg::OP_ERASE: begin
					if (exact && r_reg.byte_cnt == 11'd4 && may_write) begin
						r_next.state = spid_pkg::ST_ERASE;
						r_next.tmr   = 16'(ERASE_CYC - 1);
						r_next.idx   = 11'd0;
						r_next.area  = area_of(r_reg.addr);
					end
				end
				spid_pkg::OP_PROG: begin
					if (exact && r_reg.byte_cnt >= 11'd5 && may_write && !r_reg.ovr) begin
						r_next.state = spid_pkg::ST_PROG;
						r_next.tmr   = 16'(PROG_CYC - 1);
						r_next.idx   = 11'd0;
						r_next.area  = area_of(r_reg.addr);
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			r_reg       <= '0;
			r_reg.cs_p  <= 3'b111;
			r_reg.state <= spid_pkg::ST_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	// staged byte flags: cleared by a new program, set as bytes drain
	always_ff @(posedge clk_i) begin
		if (srst_i || clr_stage) begin
			stage_vld_reg <= '0;
		end else if (pop) begin
			stage_vld_reg[r_reg.fq[r_reg.f_rp][17:8]] <= 1'b1;
		end
	end

	// arrays: erase fills with ones, program only clears bits
	always_ff @(posedge clk_i) begin
		if (pop)
			stage_mem[r_reg.fq[r_reg.f_rp][17:8]] <= r_reg.fq[r_reg.f_rp][7:0];
		if (r_reg.state == spid_pkg::ST_ERASE && !r_reg.idx[10])
			sec_mem[{r_reg.area, r_reg.idx[9:0]}] <= spid_pkg::ERASED;
		if (r_reg.state == spid_pkg::ST_PROG && !r_reg.idx[10] &&
				stage_vld_reg[r_reg.idx[9:0]])
			sec_mem[{r_reg.area, r_reg.idx[9:0]}] <=
				sec_mem[{r_reg.area, r_reg.idx[9:0]}] & stage_mem[r_reg.idx[9:0]];
	end

	// outputs from flops; so_oe_o gated by select, write_in_progress_o decoded from state
	assign so_o                 = r_reg.so;
	assign so_oe_o              = r_reg.so_en && cs_low;
	assign write_in_progress_o  = write_in_progress;
	assign write_enable_latch_o = r_reg.write_enable_latch;
	assign deep_sleep_o         = r_reg.asleep;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_ERASE_END: assert property (@(posedge clk_i) disable iff (srst_i)
		(r_reg.state == spid_pkg::ST_ERASE && r_reg.tmr == 16'h0000) |=>
		!write_in_progress_o && !write_enable_latch_o)
		else $error("erase end did not clear wip and latch");
	AST_PROG_END: assert property (@(posedge clk_i) disable iff (srst_i)
		(r_reg.state == spid_pkg::ST_PROG && r_reg.tmr == 16'h0000) |=>
		!write_in_progress_o && !write_enable_latch_o)
		else $error("program end did not clear wip and latch");
	AST_WIP_HOLD: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(write_in_progress_o) |-> write_in_progress_o [*8])
		else $error("wip dropped early");
	AST_LOCKED: assert property (@(posedge clk_i) disable iff (srst_i)
		(cs_rise && security_lock_bits_i[area_of(r_reg.addr)]) |=> !$rose(write_in_progress))
		else $error("locked area started a cycle");
	AST_NO_WEL: assert property (@(posedge clk_i) disable iff (srst_i)
		(cs_rise && !r_reg.write_enable_latch) |=> !$rose(write_in_progress))
		else $error("cycle started without latch");
	AST_SLEEP_GATE: assert property (@(posedge clk_i) disable iff (srst_i)
		(byte_done && r_reg.byte_cnt == 11'd0 && r_reg.asleep &&
		in_byte != spid_pkg::OP_SIG) |=> r_reg.opcode == spid_pkg::OP_NONE)
		else $error("instruction taken while asleep");
	AST_RDP_EXACT: assert property (@(posedge clk_i) disable iff (srst_i)
		(cs_rise && r_reg.asleep && r_reg.byte_cnt == 11'd1 && !exact) |=>
		r_reg.state != spid_pkg::ST_WAKEW)
		else $error("release on partial byte");
	AST_WAKE: assert property (@(posedge clk_i) disable iff (srst_i)
		(r_reg.state == spid_pkg::ST_WAKEW && r_reg.tmr == 16'h0000) |=> !deep_sleep_o)
		else $error("wake delay did not release");
	AST_WRAP: assert property (@(posedge clk_i) disable iff (srst_i)
		(byte_done && r_reg.opcode == spid_pkg::OP_READ && r_reg.byte_cnt >= 11'd4 &&
		r_reg.off == spid_pkg::OFF_LAST) |=> r_reg.off == 10'h000)
		else $error("read offset did not wrap");

endmodule

// ---- bench/spid_host.sv ----
`timescale 1ns/10ps

// ----------------------------------------------------------------
// host side of the serial link, mode 0
// ----------------------------------------------------------------
module spid_host (
	input  wire logic clk_i,
	input  wire logic so_i,
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      si_o
);
	logic busy;

	// select released, clock parked low at time zero
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		si_o   = 1'b0;
		busy   = 1'b0;
	end

	// idle data line toggles so a stale bit never looks valid
	always @(posedge clk_i) begin
		if (!busy) si_o <= ~si_o;
	end

	// n bits msb first; 5 clk low, 3 clk high gives the 400 ns clock
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			@(posedge clk_i);
			sclk_o <= 1'b0;
			si_o   <= tx[i];
			repeat (5) @(posedge clk_i);
			sclk_o <= 1'b1;
			rx[i] = so_i;
			repeat (2) @(posedge clk_i);
		end
		@(posedge clk_i);
		sclk_o <= 1'b0;
	endtask

	task automatic begin_f();
		busy = 1'b1;
		@(posedge clk_i);
		cs_n_o <= 1'b0;
	endtask

	// select held high a while, so frames never crowd each other
	task automatic end_f();
		@(posedge clk_i);
		cs_n_o <= 1'b1;
		busy = 1'b0;
		repeat (6) @(posedge clk_i);
	endtask
endmodule

// ---- bench/tb_secreg_powerdown_id_cmds.sv ----
`timescale 1ns/10ps

module tb_secreg_powerdown_id_cmds;
	localparam int EC = 1100;
	localparam int PC = 1100;
	localparam int SC = 4;
	localparam int WC = 40;

	logic       clk  = 1'b0;
	logic       srst = 1'b1;
	logic [2:0] lock = 3'h0;
	logic       cs_n, sclk, si, so, so_oe, write_in_progress, write_enable_latch, slp;
	logic [7:0] rx_q[$];
	logic [7:0] d[$];
	logic       oe_seen;
	int         wip_cnt, fail_count, checks_done;

	// ----------------------------------------------------------------
	// clock, design and host
	// ----------------------------------------------------------------
	always #25 clk = ~clk;

	spid_flash #(.ERASE_CYC(EC), .PROG_CYC(PC), .SLEEP_CYC(SC), .WAKE_CYC(WC)) i_dut (
		.clk_i(clk), .srst_i(srst), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
		.security_lock_bits_i(lock), .so_o(so), .so_oe_o(so_oe),
		.write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch), .deep_sleep_o(slp)
	);

	spid_host i_host (.clk_i(clk), .so_i(so), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));

	// observers on the settled half of the cycle
	always @(negedge clk) begin
		if (write_in_progress === 1'b1) wip_cnt++;
		if (so_oe === 1'b1) oe_seen = 1'b1;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		if (fail_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one whole frame: opcode, na header bytes, queued data, nrd reads
	task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na, input int nrd);
		logic [7:0] r;
		rx_q = {};
		oe_seen = 1'b0;
		if (op == spid_pkg::OP_ERASE || op == spid_pkg::OP_PROG) wip_cnt = 0;
		i_host.begin_f();
		i_host.xfer(op, 8, r);
		for (int i = na - 1; i >= 0; i--) i_host.xfer(a[8*i+:8], 8, r);
		foreach (d[i]) i_host.xfer(d[i], 8, r);
		repeat (nrd) begin
			i_host.xfer(8'h00, 8, r);
			rx_q.push_back(r);
		end
		i_host.end_f();
		d = {};
	endtask

	// wait out a self-timed cycle; n is 0 where nothing may start
	task automatic done(input int n);
		repeat (8) @(negedge clk);
		for (int i = 0; i < 2000 && write_in_progress !== 1'b0; i++) @(negedge clk);
		chk("busy cycles", wip_cnt, n);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] e;
		logic [7:0] pd[$];
		void'($urandom(20));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk("oe after reset", so_oe, 0);
		chk("wip after reset", write_in_progress, 0);
		chk("wel after reset", write_enable_latch, 0);
		chk("sleep after reset", slp, 0);
		cmd(spid_pkg::OP_ERASE, 24'h001000, 3, 0);
		done(0);
		cmd(spid_pkg::OP_WRITE_ENABLE_INSTR, 0, 0, 0);
		chk("latch set", write_enable_latch, 1);
		cmd(spid_pkg::OP_ERASE, 24'h001000, 3, 0);
		cmd(spid_pkg::OP_RDSR, 0, 0, 1);
		chk("status in erase", rx_q[0], 8'h03);
		cmd(spid_pkg::OP_SIG, 0, 0, 1);
		chk("signature in erase", oe_seen, 0);
		done(EC);
		chk("latch after erase", write_enable_latch, 0);
		// random bytes across the top of area 1, offsets wrap
		// latch first: a queued byte would ride along and spoil the enable frame
		cmd(spid_pkg::OP_WRITE_ENABLE_INSTR, 0, 0, 0);
		for (int i = 0; i < 4; i++) d.push_back(8'($urandom));
		pd = d;
		cmd(spid_pkg::OP_PROG, 24'h0013FE, 3, 0);
		done(PC);
		chk("latch after program", write_enable_latch, 0);
		cmd(spid_pkg::OP_READ, 32'h0013FE00, 4, 5);
		for (int i = 0; i < 4; i++) chk("read data", rx_q[i], pd[i]);
		chk("read unwritten", rx_q[4], 8'hFF);
		// refusals with the latch set: locked, bad area, mid-byte select
		@(posedge clk) lock <= 3'b010;
		cmd(spid_pkg::OP_WRITE_ENABLE_INSTR, 0, 0, 0);
		d.push_back(8'h00);
		cmd(spid_pkg::OP_PROG, 24'h002000, 3, 0);
		done(0);
		cmd(spid_pkg::OP_ERASE, 24'h002000, 3, 0);
		done(0);
		cmd(spid_pkg::OP_ERASE, 24'h000000, 3, 0);
		done(0);
		@(posedge clk) lock <= 3'b000;
		i_host.begin_f();
		i_host.xfer(spid_pkg::OP_ERASE, 8, e);
		i_host.xfer(8'h00, 8, e);
		i_host.xfer(8'h20, 8, e);
		i_host.xfer(8'h00, 3, e);
		i_host.end_f();
		done(0);
		chk("latch kept", write_enable_latch, 1);
		cmd(spid_pkg::OP_ERASE, 24'h002000, 3, 0);
		done(EC);
		// identification bytes in both start orders
		for (int k = 0; k < 2; k++) begin
			cmd(spid_pkg::OP_ID, k, 3, 4);
			for (int i = 0; i < 4; i++) begin
				e = ((i + k) % 2 == 0) ? spid_pkg::MFR_CODE : spid_pkg::DEV_CODE;
				chk("id byte", rx_q[i], e);
			end
		end
		// asleep: writes and status ignored, short release ignored
		cmd(spid_pkg::OP_SLEEP, 0, 0, 0);
		repeat (SC + 8) @(negedge clk);
		chk("asleep", slp, 1);
		cmd(spid_pkg::OP_WRITE_ENABLE_INSTR, 0, 0, 0);
		cmd(spid_pkg::OP_RDSR, 0, 0, 1);
		chk("status asleep", oe_seen, 0);
		chk("latch asleep", write_enable_latch, 0);
		i_host.begin_f();
		i_host.xfer(spid_pkg::OP_SIG, 5, e);
		i_host.end_f();
		repeat (WC + 8) @(negedge clk);
		chk("short release", slp, 1);
		cmd(spid_pkg::OP_SIG, 0, 0, 0);
		chk("wake delay", slp, 1);
		repeat (WC + 8) @(negedge clk);
		chk("released", slp, 0);
		cmd(spid_pkg::OP_SLEEP, 0, 0, 0);
		repeat (SC + 8) @(negedge clk);
		cmd(spid_pkg::OP_SIG, 0, 0, 2);
		chk("signature", rx_q[0], spid_pkg::SIG_CODE);
		chk("signature again", rx_q[1], spid_pkg::SIG_CODE);
		repeat (WC + 8) @(negedge clk);
		chk("woken", slp, 0);
		close_out();
	end

	// hang guard, well beyond the roughly 9k cycles of the sequence
	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		close_out();
	end
endmodule
